// ==== inc/rail_seq_consts.svh ====
// Constants for the rail strobe assignment block: offsets, fields, resets and timing.
//
// Operation
// - The 1.8-V backup converter strobe code sits at bits 5:4, resets to 1, code 1 is strobe 1, code 2 is strobe 2.
// - The 1-V backup converter strobe code sits at bits 1:0, resets to 0, code 1 is strobe 1, code 2 is strobe 2.
// - Backup codes 0 and 3 leave that converter untouched by the sequencer.
// - Strobes 1 and 2 run only while the freshness seal is intact and are skipped once it is broken.
// - Once the seal is broken the sequencer never switches off either backup converter.
// - A 4-bit code from 3h to Ah switches its rail on at the strobe of the same number.
// - A 4-bit code of 0h to 2h or Bh to Fh leaves its rail untouched by the sequencer.
// - The backup select register is at index 24h, resets to 10h, and bits 7:6 and 3:2 read zero.
// - Index 25h holds the load switch code in 7:4 and the regulator code in 3:0, reset 88h.
// - Index 26h holds output three code in 7:4 (reset 0h) and output one code in 3:0 (reset 8h).
// - Each gap between strobes is 2 ms or 5 ms by one select bit, after one strobe and before the next.
`ifndef RAIL_SEQ_CONSTS_SVH
`define RAIL_SEQ_CONSTS_SVH

// ==================================================================
// Register indices (byte address is four times the index)
`define RS_IDX_BACKUP 6'h24
`define RS_IDX_SWREG 6'h25
`define RS_IDX_GENOUT 6'h26
`define RS_IDX_CTRL 6'h27
`define RS_IDX_DELAY 6'h28
`define RS_IDX_STATUS 6'h29
`define RS_IDX_UNLOCK 6'h2A

// ==================================================================
// Reset values and field positions
`define RS_RST_BACKUP 8'h10
`define RS_RST_SWREG 8'h88
`define RS_RST_GENOUT 8'h08
`define RS_BK_WMASK 8'h33
`define RS_BK_HIGH_LSB 4
`define RS_BK_LOW_LSB 0
`define RS_HI_NIB_LSB 4
`define RS_LO_NIB_LSB 0
`define RS_CTL_UP 0
`define RS_CTL_DOWN 1
`define RS_CTL_SEAL 2
`define RS_UNLOCK_KEY 8'h5A

// ==================================================================
// Strobe numbering and timing
`define RS_STROBE_FIRST 4'h1
`define RS_STROBE_SEALED 4'h3
`define RS_STROBE_LAST 4'hA
`define RS_CLK_NS 40
`define RS_TICK_NS 1000000
`define RS_DLY_SHORT_MS 3'd2
`define RS_DLY_LONG_MS 3'd5

`endif

// ==== inc/rail_seq_pkg.sv ====
// Types shared by the rail strobe assignment block.
package rail_seq_pkg;
    localparam int RAILS = 6;
    localparam int BACKUP_RAILS = 2;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_STROBE, SEQ_WAIT} seq_state_t;

    typedef struct packed {
        logic ack;
        logic [15:0] rdat;
        logic [7:0] selBackup;
        logic [7:0] selSwReg;
        logic [7:0] selGen;
        logic [8:0] dlySel;
        logic unlocked;
        logic sealBroken;
        seq_state_t fsm;
        logic down;
        logic [3:0] step;
        logic [2:0] ticks;
        logic [5:0] railEn;
    } top_state_t;
endpackage : rail_seq_pkg

// ==== inc/strobe_if.sv ====
// Carries the current strobe number and the rail codes to the decoder and its hits back.
`timescale 1ns/10ps
interface strobe_if;
    logic [3:0] step;
    logic [5:0][3:0] code;
    logic [5:0] hit;
    modport seq (output step, output code, input hit);
    modport dec (input step, input code, output hit);
endinterface : strobe_if

// ==== hw/ms_tick_divider.sv ====
// Divider giving a one-cycle enable pulse once per millisecond.
`timescale 1ns/10ps
module ms_tick_divider #(
    parameter int unsigned CYCLES = 25000
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Restart and pulse.
    input wire logic clr,
    output logic tick
);
    localparam int CW = $clog2(CYCLES);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } div_state_t;

    div_state_t q;
    div_state_t d;

    // A restart realigns the count so a delay is never cut short by a stale phase.
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (clr) begin
            d.cnt = '0;
        end else if (q.cnt == LAST) begin
            d.cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = CW'(q.cnt + 1'b1);
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '{cnt: '0, tick: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_tick_gap;
        tick |=> !tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("Tick lasted more than one cycle.");
endmodule : ms_tick_divider

// ==== hw/rail_strobe_decode.sv ====
// Matches each rail's strobe code against the strobe now being executed.
`timescale 1ns/10ps
module rail_strobe_decode (
    // Strobe number in, hits out.
    strobe_if.dec sb
);
    import rail_seq_pkg::*;

    // The low rails have 2-bit codes, the rest 4-bit codes with a wider legal span.
    for (genvar i = 0; i < RAILS; i++) begin : g_rail
        if (i < BACKUP_RAILS) begin : g_backup
            assign sb.hit[i] = (sb.code[i] == sb.step)
                && (sb.code[i] == 4'h1 || sb.code[i] == 4'h2);
        end else begin : g_main
            assign sb.hit[i] = (sb.code[i] == sb.step)
                && (sb.code[i] >= 4'h3) && (sb.code[i] <= 4'hA);
        end
    end
endmodule : rail_strobe_decode

// ==== hw/rail_strobe_assignment.sv ====
// Strobe assignment registers and power sequencer with a classic Wishbone slave.
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/10ps
`include "rail_seq_consts.svh"
module rail_strobe_assignment #(
    parameter int unsigned TICK_CYCLES = `RS_TICK_NS / `RS_CLK_NS
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Rail enables and sequencer status.
    output logic [rail_seq_pkg::RAILS-1:0] railEnable,
    output logic seqBusy
);
    import rail_seq_pkg::*;

    top_state_t q;
    top_state_t d;
    logic wbHit;
    logic wr;
    logic [5:0] idx;
    logic cmdUp;
    logic cmdDown;
    logic tick;
    logic tickClr;
    logic [3:0] gap;
    logic [2:0] target;
    logic [3:0] endStep;
    logic [5:0] keepMask;
    logic [5:0] hit;

    strobe_if sbus ();

    // ==================================================================
    // Strobe decoding and millisecond timebase
    // Rails 0 and 1 are the low and high backup converters, 2 the regulator,
    // 3 the load switch, 4 and 5 the general outputs one and three.
    assign sbus.step = q.step;
    assign sbus.code[0] = {2'b00, q.selBackup[`RS_BK_LOW_LSB +: 2]};
    assign sbus.code[1] = {2'b00, q.selBackup[`RS_BK_HIGH_LSB +: 2]};
    assign sbus.code[2] = q.selSwReg[`RS_LO_NIB_LSB +: 4];
    assign sbus.code[3] = q.selSwReg[`RS_HI_NIB_LSB +: 4];
    assign sbus.code[4] = q.selGen[`RS_LO_NIB_LSB +: 4];
    assign sbus.code[5] = q.selGen[`RS_HI_NIB_LSB +: 4];
    assign hit = sbus.hit;

    rail_strobe_decode u_decode (
        .sb(sbus.dec)
    );

    ms_tick_divider #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .sys_rst(sys_rst),
        .clr(tickClr),
        .tick(tick)
    );

    // ==================================================================
    // Next-state logic
    // Bus access, register writes and the sequencer share one next state so
    // that a locked write and a running sequence can never race each other.
    always_comb begin
        d = q;
        wbHit = wb_cyc_i & wb_stb_i & ~q.ack;
        wr = wbHit & wb_we_i;
        idx = wb_adr_i[7:2];
        cmdUp = 1'b0;
        cmdDown = 1'b0;
        tickClr = 1'b0;
        d.ack = wbHit;
        gap = q.down ? 4'(q.step - 4'h2) : 4'(q.step - 4'h1);
        target = q.dlySel[gap] ? `RS_DLY_LONG_MS : `RS_DLY_SHORT_MS;
        endStep = q.down ? (q.sealBroken ? `RS_STROBE_SEALED : `RS_STROBE_FIRST)
                         : `RS_STROBE_LAST;
        keepMask = q.sealBroken ? 6'h3C : 6'h3F;

        // Reads return the register in the low bits, zero above and off the map.
        if (wbHit) begin
            case (idx)
                `RS_IDX_BACKUP: d.rdat = {8'h00, q.selBackup & `RS_BK_WMASK};
                `RS_IDX_SWREG: d.rdat = {8'h00, q.selSwReg};
                `RS_IDX_GENOUT: d.rdat = {8'h00, q.selGen};
                `RS_IDX_DELAY: d.rdat = {7'h00, q.dlySel};
                `RS_IDX_STATUS: d.rdat = {q.railEn, q.step, q.unlocked,
                                          q.fsm != SEQ_IDLE, q.down, 2'b00,
                                          q.sealBroken};
                default: d.rdat = 16'h0000;
            endcase
        end

        // Writes to the sequencing registers need a fresh unlock each time.
        if (wr && wb_sel_i[0]) begin
            case (idx)
                `RS_IDX_BACKUP: begin
                    if (q.unlocked) begin
                        d.selBackup = wb_dat_i[7:0] & `RS_BK_WMASK;
                    end
                    d.unlocked = 1'b0;
                end
                `RS_IDX_SWREG: begin
                    if (q.unlocked) begin
                        d.selSwReg = wb_dat_i[7:0];
                    end
                    d.unlocked = 1'b0;
                end
                `RS_IDX_GENOUT: begin
                    if (q.unlocked) begin
                        d.selGen = wb_dat_i[7:0];
                    end
                    d.unlocked = 1'b0;
                end
                `RS_IDX_DELAY: begin
                    if (q.unlocked && wb_sel_i[1]) begin
                        d.dlySel = wb_dat_i[8:0];
                    end
                    d.unlocked = 1'b0;
                end
                `RS_IDX_CTRL: begin
                    cmdUp = wb_dat_i[`RS_CTL_UP];
                    cmdDown = wb_dat_i[`RS_CTL_DOWN];
                    if (wb_dat_i[`RS_CTL_SEAL]) begin
                        d.sealBroken = 1'b1;
                    end
                end
                `RS_IDX_UNLOCK: d.unlocked = (wb_dat_i[7:0] == `RS_UNLOCK_KEY);
                default: d.unlocked = q.unlocked;
            endcase
        end

        // Sequencer: commands arriving while a sequence runs are dropped.
        unique case (q.fsm)
            SEQ_IDLE: begin
                if (cmdUp || cmdDown) begin
                    d.down = ~cmdUp;
                    d.fsm = SEQ_STROBE;
                    if (cmdUp) begin
                        d.step = d.sealBroken ? `RS_STROBE_SEALED : `RS_STROBE_FIRST;
                    end else begin
                        d.step = `RS_STROBE_LAST;
                    end
                end
            end
            SEQ_STROBE: begin
                if (q.down) begin
                    d.railEn = q.railEn & ~(hit & keepMask);
                end else begin
                    d.railEn = q.railEn | hit;
                end
                if (q.step == endStep) begin
                    d.fsm = SEQ_IDLE;
                end else begin
                    d.fsm = SEQ_WAIT;
                    d.ticks = 3'd0;
                    tickClr = 1'b1;
                end
            end
            SEQ_WAIT: begin
                if (tick) begin
                    d.ticks = 3'(q.ticks + 3'd1);
                    if (3'(q.ticks + 3'd1) == target) begin
                        d.fsm = SEQ_STROBE;
                        d.step = q.down ? 4'(q.step - 4'h1) : 4'(q.step + 4'h1);
                    end
                end
            end
        endcase
    end

    // ==================================================================
    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '{ack: 1'b0, rdat: 16'h0000,
                   selBackup: `RS_RST_BACKUP,
                   selSwReg: `RS_RST_SWREG,
                   selGen: `RS_RST_GENOUT,
                   dlySel: 9'h000, unlocked: 1'b0, sealBroken: 1'b0,
                   fsm: SEQ_IDLE, down: 1'b0, step: 4'h0, ticks: 3'd0,
                   railEn: 6'h00};
        end else begin
            q <= d;
        end
    end

    // Outputs all come straight from the state register.
    assign wb_ack_o = q.ack;
    assign wb_dat_o = {16'h0000, q.rdat};
    assign railEnable = q.railEn;
    assign seqBusy = q.fsm != SEQ_IDLE;

    // ==================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("Ack held for two cycles.");

    property p_reset_vals;
        $fell(sys_rst) |-> q.selBackup == 8'h10 && q.selSwReg == 8'h88 && q.selGen == 8'h08;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("Wrong reset value.");

    property p_reserved_zero;
        (q.selBackup & 8'hCC) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit set.");

    property p_locked_write;
        (wr && wb_sel_i[0] && !q.unlocked && idx == 6'h25) |=> $stable(q.selSwReg);
    endproperty
    a_locked_write: assert property (p_locked_write) else $error("Locked write landed.");

    property p_sealed_skip;
        (q.sealBroken && q.fsm == SEQ_STROBE) |-> q.step >= 4'h3;
    endproperty
    a_sealed_skip: assert property (p_sealed_skip) else $error("Early strobe after seal.");

    property p_backup_kept;
        (q.sealBroken && q.railEn[0]) |=> q.railEn[0];
    endproperty
    a_backup_kept: assert property (p_backup_kept) else $error("Backup rail switched off.");

    property p_backup_code;
        $rose(railEnable[1]) |-> $past(q.step) == {2'b00, $past(q.selBackup[5:4])}
            && $past(q.step) inside {4'h1, 4'h2};
    endproperty
    a_backup_code: assert property (p_backup_code) else $error("Backup on at wrong strobe.");

    property p_main_code;
        $rose(railEnable[3]) |-> $past(q.step) == $past(q.selSwReg[7:4])
            && $past(q.step) >= 4'h3 && $past(q.step) <= 4'hA;
    endproperty
    a_main_code: assert property (p_main_code) else $error("Switch on at wrong strobe.");

    property p_wait_len;
        (q.fsm == SEQ_WAIT && d.fsm == SEQ_STROBE) |-> tick
            && (3'(q.ticks + 3'd1) == 3'd2 || 3'(q.ticks + 3'd1) == 3'd5);
    endproperty
    a_wait_len: assert property (p_wait_len) else $error("Gap is neither 2 nor 5 ms.");
endmodule : rail_strobe_assignment

// ==== dv/rail_load_model.sv ====
// Behavioural regulator and switch loads that stamp when each rail enable moves.
`timescale 1ns/10ps
module rail_load_model (
    // Clock.
    input wire logic clk,
    // Enables seen at the regulator inputs.
    input wire logic [rail_seq_pkg::RAILS-1:0] railEnable,
    // Cycle count and last on and off stamps per rail.
    output logic [31:0] now,
    output logic [rail_seq_pkg::RAILS-1:0][31:0] riseAt,
    output logic [rail_seq_pkg::RAILS-1:0][31:0] fallAt
);
    import rail_seq_pkg::*;
    logic [RAILS-1:0] prevEn = '0;
    // ==================================================================
    // Stamps
    // The loads only watch: a rail draws nothing from the sequencer, so no reply.
    always @(posedge clk) begin
        now <= now + 1;
        prevEn <= railEnable;
        for (int i = 0; i < RAILS; i++) begin
            if (railEnable[i] && !prevEn[i]) riseAt[i] <= now;
            if (!railEnable[i] && prevEn[i]) fallAt[i] <= now;
        end
    end
    initial now = '0;
endmodule : rail_load_model

// ==== dv/tb_rail_strobe_assignment.sv ====
// Self-checking bench for the rail strobe assignment block.
`timescale 1ns/10ps
`include "rail_seq_consts.svh"
module tb_rail_strobe_assignment;
    import rail_seq_pkg::*;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatW = 32'h0;
    logic [31:0] wbDatR;
    logic wbAck;
    logic [RAILS-1:0] railEnable;
    logic seqBusy;
    logic [31:0] now;
    logic [RAILS-1:0][31:0] riseAt;
    logic [RAILS-1:0][31:0] fallAt;
    int failures = 0;
    int nTests = 0;
    // ==================================================================
    // Clock, design and loads
    // Four cycles a tick keeps the gaps at 10 or 22 cycles.
    always #20 clk = ~clk;
    rail_strobe_assignment #(.TICK_CYCLES(4)) u_rail_strobe_assignment (.clk(clk),
        .sys_rst(sysRst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck), .railEnable(railEnable), .seqBusy(seqBusy));
    rail_load_model u_rail_load_model (.clk(clk), .railEnable(railEnable), .now(now),
        .riseAt(riseAt), .fallAt(fallAt));
    // ==================================================================
    // Shared tasks
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d.", nTests, failures);
        if (failures == 0 && nTests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        nTests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic span(input string name, input int lo, input int hi, input logic [31:0] got);
        nTests++;
        if (!(got >= lo && got <= hi)) begin
            failures++;
            $display("MISMATCH %s expected %0d to %0d seen %0d", name, lo, hi, got);
        end
    endtask : span
    // One classic cycle; the request stands until ack is sampled at an edge.
    task automatic wb(input logic we, input logic [5:0] idx, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= {idx, 2'b00};
        wbSel <= 4'hF; wbDatW <= d;
        do @(posedge clk); while (wbAck !== 1'b1);
        q = wbDatR;
        wbCyc <= 1'b0; wbStb <= 1'b0;
    endtask : wb
    task automatic rdChk(input logic [5:0] idx, input logic [7:0] exp, input string name);
        logic [31:0] q;
        wb(1'b0, idx, 32'h0, q);
        chk(name, {24'h0, exp}, q);
    endtask : rdChk
    task automatic wrProt(input logic [5:0] idx, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, `RS_IDX_UNLOCK, {24'h0, `RS_UNLOCK_KEY}, q);
        wb(1'b1, idx, d, q);
    endtask : wrProt
    // Starts a command and waits, bounded, for the sequencer to go idle.
    task automatic runSeq(input logic [31:0] cmd, output logic [31:0] t0);
        logic [31:0] q;
        wb(1'b1, `RS_IDX_CTRL, cmd, q);
        t0 = now;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 600 && seqBusy !== 1'b0; i++) @(posedge clk);
        @(posedge clk);
        chk("seqBusy", 32'h0, {31'h0, seqBusy});
    endtask : runSeq
    // ==================================================================
    // Scenarios
    task automatic t_reset();
        rdChk(`RS_IDX_BACKUP, 8'h10, "backup reset");
        rdChk(`RS_IDX_SWREG, 8'h88, "switch reset");
        rdChk(`RS_IDX_GENOUT, 8'h08, "genout reset");
        rdChk(6'h3F, 8'h00, "unmapped");
    endtask : t_reset
    task automatic t_lock();
        logic [31:0] q;
        wb(1'b1, `RS_IDX_SWREG, 32'h11, q);
        rdChk(`RS_IDX_SWREG, 8'h88, "locked write");
        wrProt(`RS_IDX_BACKUP, 32'hFF);
        rdChk(`RS_IDX_BACKUP, 8'h33, "reserved bits");
    endtask : t_lock
    task automatic t_mixed();
        logic [31:0] t0;
        wrProt(`RS_IDX_BACKUP, 32'h21);
        wrProt(`RS_IDX_SWREG, 32'hA3);
        wrProt(`RS_IDX_GENOUT, 32'hB5);
        wrProt(`RS_IDX_DELAY, 32'h001);
        runSeq(32'h1, t0);
        chk("rails up", 32'h1F, {26'h0, railEnable});
        span("gap long", 20, 23, riseAt[1] - riseAt[0]);
        span("gap short", 8, 11, riseAt[2] - riseAt[1]);
        span("strobe5", 16, 22, riseAt[4] - riseAt[2]);
        span("strobe10", 40, 55, riseAt[3] - riseAt[4]);
        runSeq(32'h2, t0);
        chk("rails down", 32'h0, {26'h0, railEnable});
        span("down order a", 1, 200, fallAt[4] - fallAt[3]);
        span("down order b", 1, 200, fallAt[2] - fallAt[4]);
        span("down order c", 1, 200, fallAt[0] - fallAt[2]);
    endtask : t_mixed
    // Every 4-bit code on the regulator field, with the backup rails left alone.
    task automatic t_sweep();
        logic [31:0] t0;
        wrProt(`RS_IDX_BACKUP, 32'h00);
        wrProt(`RS_IDX_GENOUT, 32'h00);
        // Every gap short, so the expected window is a plain multiple of 2 ms.
        wrProt(`RS_IDX_DELAY, 32'h000);
        for (int c = 0; c < 16; c++) begin
            wrProt(`RS_IDX_SWREG, c);
            runSeq(32'h1, t0);
            chk("sweep on", (c >= 3 && c <= 10) ? 32'h04 : 32'h0, railEnable);
            if (c >= 3 && c <= 10) span("sweep time", (c - 1) * 8, (c - 1) * 11 + 4, riseAt[2] - t0);
            runSeq(32'h2, t0);
            chk("sweep off", 32'h0, {26'h0, railEnable});
        end
    endtask : t_sweep
    task automatic t_seal();
        logic [31:0] t0;
        logic [31:0] q;
        wrProt(`RS_IDX_BACKUP, 32'h13);
        wrProt(`RS_IDX_SWREG, 32'h03);
        runSeq(32'h1, t0);
        chk("code three", 32'h06, {26'h0, railEnable});
        wb(1'b1, `RS_IDX_CTRL, 32'h4, q);
        runSeq(32'h2, t0);
        chk("sealed down", 32'h02, {26'h0, railEnable});
        wrProt(`RS_IDX_BACKUP, 32'h02);
        runSeq(32'h1, t0);
        chk("sealed up", 32'h06, {26'h0, railEnable});
        span("sealed start", 0, 6, riseAt[2] - t0);
        runSeq(32'h2, t0);
        chk("sealed down 2", 32'h02, {26'h0, railEnable});
    endtask : t_seal
    // ==================================================================
    // Main sequence and watchdog
    initial begin
        repeat (5) @(posedge clk);
        sysRst <= 1'b0;
        t_reset();
        t_lock();
        t_mixed();
        t_sweep();
        t_seal();
        close_out();
    end
    initial begin
        #(40 * 30000);
        failures++;
        close_out();
    end
endmodule : tb_rail_strobe_assignment
